// File: bench/bhl_link_chk.sv
// Port-level assertions of the block handshake link layer
`timescale 1ns/1ps
module bhl_link_chk #(
  parameter int SETTLE_CYCLES = 20, // Settle wait after connect
  parameter int BLINK_CYCLES = 8 // Blink half period
) (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic [1:0] mode, // Handshake mode
  input wire logic [1:0] mode_default, // Factory mode
  input wire logic line_break, // Break on input
  input wire logic hw_ready_n, // Hardware handshake in
  input wire logic hw_ready_present, // Input wired
  input wire logic hw_send_ok, // Sending allowed
  input wire logic tx_valid, // Character out
  input wire logic [7:0] tx_data, // Its value
  input wire logic tx_ready, // Taken
  input wire logic tx_est, // Tx way set
  input wire logic rx_est, // Rx way set
  input wire logic io_lamp // Status lamp
);
  // ----
  // Helpers
  // ----
  logic syn_taken;
  assign syn_taken = tx_valid && tx_ready && tx_data == bhl_pkg::CHAR_SYN;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence cr_taken_s;
    tx_valid && tx_ready && tx_data == bhl_pkg::CHAR_CR && mode == 2'h3;
  endsequence
  sequence both_set_s;
    (tx_est && rx_est && !line_break && mode == 2'h3) [*2];
  endsequence
  // Open input reads as permission, so a cut wire never stalls output
  hw_open_ok_a: assert property (hw_send_ok == (!hw_ready_present || !hw_ready_n))
    else $error("hardware handshake permission wrong");
  factory_mode_a: assert property (mode_default == 2'h0)
    else $error("factory mode is not pause");
  lamp_break_a: assert property (line_break |-> !io_lamp)
    else $error("lamp lit during break");
  lamp_steady_a: assert property (both_set_s |-> io_lamp)
    else $error("lamp not steady with both ways set");
  no_ctrl_a: assert property (tx_valid && (mode != 2'h3 || line_break)
    |-> tx_data != bhl_pkg::CHAR_SYN && tx_data != bhl_pkg::CHAR_ACK)
    else $error("control character outside handshake");
  break_cancel_a: assert property (line_break |=> !tx_est && !rx_est)
    else $error("break did not cancel handshake");
  est_hold_a: assert property (tx_est && mode == 2'h3 && !line_break |=> tx_est)
    else $error("transmit handshake dropped");
  rx_set_a: assert property ($rose(rx_est) |-> $past(syn_taken))
    else $error("receive way set without echo");
  crlf_order_a: assert property (cr_taken_s |=> tx_valid && tx_data == bhl_pkg::CHAR_LF)
    else $error("line feed missing after carriage return");
endmodule : bhl_link_chk
bind bhl_link bhl_link_chk #(.SETTLE_CYCLES(SETTLE_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .mode(mode), .mode_default(mode_default),
  .line_break(line_break), .hw_ready_n(hw_ready_n), .hw_ready_present(hw_ready_present),
  .hw_send_ok(hw_send_ok), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .tx_est(tx_est), .rx_est(rx_est), .io_lamp(io_lamp)
);

// File: bench/bhl_link_tb_top.sv
// Self-checking bench of the block handshake link layer
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin total_checks++; if ((ac) !== (ex)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, ac); end end
module bhl_link_tb_top;
  // ----
  // Stimulus and capture
  // ----
  localparam int ST = 20;
  localparam logic [7:0] LINE [4] = '{8'h41, 8'h42, bhl_pkg::CHAR_CR, bhl_pkg::CHAR_LF};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic lf_suppress = 1'b1;
  logic line_break = 1'b0, hw_ready_n = 1'b1, hw_ready_present = 1'b0;
  logic msg_pending = 1'b0, slow = 1'b0, echo_en = 1'b0, inj_valid = 1'b0;
  logic [7:0] inj_data = 8'h00;
  logic cmd_ack_req = 1'b0;
  logic rx_cmd_valid;
  logic [7:0] rx_cmd_data;
  logic [1:0] idx = 2'h0;
  logic rx_valid, tx_valid, tx_ready, msg_ready, msg_last, tx_est, rx_est, io_lamp, hw_send_ok;
  logic [7:0] rx_data, tx_data, msg_data;
  logic [1:0] mode_default;
  logic [7:0] seen [$];
  int error_cnt = 0, total_checks = 0;
  always #5 core_clk = ~core_clk;
  // Two-character line body, always on offer
  assign msg_data = 8'h41 + {6'h00, idx};
  assign msg_last = idx == 2'h1;
  always @(posedge core_clk) if (msg_ready) idx <= msg_last ? 2'h0 : idx + 2'h1;
  always @(posedge core_clk) if (tx_valid && tx_ready) seen.push_back(tx_data);
  bhl_link #(.SETTLE_CYCLES(ST), .BLINK_CYCLES(8)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .mode(mode), .factory_load(1'b0),
    .mode_default(mode_default), .lf_suppress(lf_suppress), .line_break(line_break),
    .hw_ready_n(hw_ready_n), .hw_ready_present(hw_ready_present), .hw_send_ok(hw_send_ok),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_cmd_valid(rx_cmd_valid),
    .rx_cmd_data(rx_cmd_data), .cmd_ack_req(cmd_ack_req), .msg_pending(msg_pending),
    .msg_valid(1'b1), .msg_data(msg_data),
    .msg_last(msg_last), .msg_ready(msg_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .tx_est(tx_est), .rx_est(rx_est), .io_lamp(io_lamp)
  );
  bhl_peer peer_u (
    .core_clk(core_clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .slow(slow),
    .echo_en(echo_en), .inj_valid(inj_valid), .inj_data(inj_data)
  );
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic send(input logic [7:0] c);
    inj_data = c;
    inj_valid = 1'b1;
    step(1);
    inj_valid = 1'b0;
  endtask : send
  task automatic t_static;
    `CHK("mode_default", 2'h0, mode_default)
    for (int i = 0; i < 4; i++) begin
      {hw_ready_present, hw_ready_n} = i[1:0];
      step(1);
      `CHK("hw_send_ok", !i[1] || !i[0], hw_send_ok)
    end
    `CHK("pause traffic", 0, seen.size())
    // Open input permits sending; outside block mode the line feed may be dropped
    hw_ready_present = 1'b0;
    msg_pending = 1'b1;
    step(4);
    msg_pending = 1'b0;
    step(2);
    `CHK("open input sends", 3, seen.size())
    `CHK("pause line end", bhl_pkg::CHAR_CR, seen[2])
  endtask : t_static
  task automatic t_inquiry;
    int n;
    logic lamp0;
    seen.delete();
    mode = 2'h3;
    n = 0;
    while (tx_valid !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    `CHK("inquiry delay", 1'b1, n >= ST && n <= ST + 3)
    `CHK("inquiry code", bhl_pkg::CHAR_SYN, tx_data)
    // Ack request before receive setup must be refused
    cmd_ack_req = 1'b1;
    step(1);
    cmd_ack_req = 1'b0;
    lamp0 = io_lamp;
    step(8);
    `CHK("lamp blinks", !lamp0, io_lamp)
    step(3 * ST - 9);
    `CHK("chars after failed setup", 1, seen.size())
    `CHK("tx way unset", 1'b0, tx_est)
  endtask : t_inquiry
  task automatic t_bidir;
    line_break = 1'b1;
    step(4);
    `CHK("lamp in break", 1'b0, io_lamp)
    line_break = 1'b0;
    step(ST - 8);
    seen.delete();
    send(bhl_pkg::CHAR_SYN);
    step(4);
    `CHK("echo", bhl_pkg::CHAR_SYN, seen[0])
    `CHK("rx way set", 1'b1, rx_est)
    `CHK("tx way apart", 1'b0, tx_est)
    echo_en = 1'b1;
    step(ST);
    `CHK("tx way set", 1'b1, tx_est)
    step(3);
    `CHK("lamp steady", 1'b1, io_lamp)
    echo_en = 1'b0;
  endtask : t_bidir
  task automatic t_command;
    seen.delete();
    cmd_ack_req = 1'b1;
    step(1);
    cmd_ack_req = 1'b0;
    step(3);
    `CHK("ack to peer", bhl_pkg::CHAR_ACK, seen[0])
    // The peer only sends its command after our acknowledge went out
    send(8'h53);
    step(1);
    `CHK("cmd valid", 1'b1, rx_cmd_valid)
    `CHK("cmd char", 8'h53, rx_cmd_data)
  endtask : t_command
  task automatic t_credit;
    seen.delete();
    msg_pending = 1'b1;
    step(30);
    `CHK("held without credit", 0, seen.size())
    send(bhl_pkg::CHAR_ACK);
    step(12);
    msg_pending = 1'b0;
    `CHK("one line", 4, seen.size())
    for (int i = 0; i < 4; i++) `CHK("line char", LINE[i], seen[i])
    seen.delete();
    slow = 1'b1;
    send(bhl_pkg::CHAR_ACK);
    step(2);
    send(bhl_pkg::CHAR_ACK);
    // Let the spare land while the first credit is still unused
    step(2);
    msg_pending = 1'b1;
    step(40);
    `CHK("spare credit dropped", 4, seen.size())
    msg_pending = 1'b0;
    line_break = 1'b1;
    step(2);
    `CHK("cancel on break", 2'h0, {tx_est, rx_est})
    `CHK("lamp off", 1'b0, io_lamp)
  endtask : t_credit
  task automatic tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    step(12);
    rst_n = 1'b1;
    step(2);
    t_static();
    t_inquiry();
    t_bidir();
    t_command();
    t_credit();
    tally_and_finish();
  end
  // Watchdog: tests need well under 500 cycles
  initial begin
    repeat (2000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : bhl_link_tb_top

// File: bench/bhl_peer.sv
// Peripheral model on the far side of the serial link
`timescale 1ns/1ps
module bhl_peer (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic tx_valid, // Character from device
  input wire logic [7:0] tx_data, // Its value
  output logic tx_ready, // Peer takes it
  output logic rx_valid, // Character to device
  output logic [7:0] rx_data, // Its value
  input wire logic slow, // Take on alternate cycles
  input wire logic echo_en, // Confirm device inquiry
  input wire logic inj_valid, // Bench asks to send
  input wire logic [7:0] inj_data // Character asked for
);
  logic phase;
  logic echoed;
  logic echo_due;
  assign tx_ready = !slow || phase;
  // Confirm only once, else two echoing ends would ping-pong forever
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      echoed <= 1'b0;
      echo_due <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      phase <= !phase;
      echoed <= echo_en && (echoed || echo_due);
      echo_due <= echo_en && !echoed && !echo_due && tx_valid && tx_ready
        && tx_data == bhl_pkg::CHAR_SYN;
      rx_valid <= inj_valid || echo_due;
      // Idle bus toggles so no stale character looks valid
      rx_data <= inj_valid ? inj_data : (echo_due ? bhl_pkg::CHAR_SYN : ~rx_data);
    end
  end
endmodule : bhl_peer

// File: hdl/bhl_ctrl_if.sv
// Interface carrying control characters from the handshake engine to the transmitter
`timescale 1ns/1ps
interface bhl_ctrl_if;
  logic req; // Control character waiting
  logic [7:0] code; // Character to send
  logic done; // Pulse: character handed to the serial transmitter
  modport engine (output req, output code, input done);
  modport sender (input req, input code, output done);
endinterface : bhl_ctrl_if

// File: hdl/bhl_link.sv
// Block handshake link layer: setup, credits, echo and link-status indicator
`timescale 1ns/1ps
module bhl_link #(
  parameter int SETTLE_CYCLES = bhl_pkg::SETTLE_CYCLES, // Settle wait after connect
  parameter int BLINK_CYCLES = bhl_pkg::BLINK_CYCLES // Half period of indicator blink
) (
  input wire logic core_clk, // System clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [1:0] mode, // Configured handshake mode
  input wire logic factory_load, // Pulse: load factory configuration
  output logic [1:0] mode_default, // Mode to store on factory load
  input wire logic lf_suppress, // Configured to drop line feed
  input wire logic line_break, // Break present on incoming data line
  input wire logic hw_ready_n, // Hardware handshake input, active low
  input wire logic hw_ready_present, // Hardware handshake input is connected
  output logic hw_send_ok, // Hardware handshake permits sending
  input wire logic rx_valid, // Pulse: character received
  input wire logic [7:0] rx_data, // Received character
  output logic rx_cmd_valid, // Pulse: command character passed on
  output logic [7:0] rx_cmd_data, // Command character
  input wire logic cmd_ack_req, // Pulse: command side ready for a command
  input wire logic msg_pending, // A message block waits to go
  input wire logic msg_valid, // Body character available
  input wire logic [7:0] msg_data, // Body character
  input wire logic msg_last, // Last body character of the line
  output logic msg_ready, // Body character taken
  output logic tx_valid, // Character to serial transmitter
  output logic [7:0] tx_data, // Character value
  input wire logic tx_ready, // Serial transmitter accepts
  output logic tx_est, // Transmit direction established
  output logic rx_est, // Receive direction established
  output logic io_lamp // Link-status indicator drive
);
  localparam int CW = 32;
  typedef struct packed {
    logic [CW-1:0] settle_cnt;
    logic settled;
    logic syn_sent;
    logic tx_est;
    logic rx_est;
    logic credit;
    logic echo_pend;
    logic ack_pend;
    logic was_block;
    logic [CW-1:0] blink_cnt;
    logic blink;
    logic [7:0] cmd_data;
    logic cmd_valid;
  } bhl_link_state_t;
  bhl_link_state_t s, next_s;
  logic block_mode;
  logic msg_start;
  logic busy;
  bhl_ctrl_if ctrl ();
  // Counter step that saturates at lim - 1, one below its limit
  function automatic logic [CW-1:0] bhl_step(input logic [CW-1:0] v, input int lim);
    bhl_step = (v >= CW'(lim - 1)) ? v : v + CW'(1);
  endfunction : bhl_step
  // ------------------------------------------------------------
  // Fixed outputs
  // ------------------------------------------------------------
  assign mode_default = bhl_pkg::MODE_DEFAULT;
  // An open input reads as ready, so an unwired printer never blocks us
  assign hw_send_ok = !hw_ready_present || !hw_ready_n;
  assign block_mode = (mode == bhl_pkg::BHL_MODE_BLOCK);
  // ------------------------------------------------------------
  // Handshake engine
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.was_block = block_mode;
    next_s.cmd_valid = 1'b0;
    // Settle timer runs from connection until SETTLE_CYCLES cycles have passed
    if (!s.settled) begin
      next_s.settle_cnt = bhl_step(s.settle_cnt, SETTLE_CYCLES);
      if (s.settle_cnt >= CW'(SETTLE_CYCLES - 1)) begin
        next_s.settled = 1'b1;
      end
    end
    if (ctrl.done) begin
      if (s.echo_pend) begin
        next_s.echo_pend = 1'b0;
        next_s.rx_est = 1'b1;
      end else if (s.ack_pend) begin
        next_s.ack_pend = 1'b0;
      end else begin
        next_s.syn_sent = 1'b1;
      end
    end
    if (msg_start) begin
      next_s.credit = 1'b0;
    end
    if (rx_valid && block_mode) begin
      if (rx_data == bhl_pkg::CHAR_ACK) begin
        // Setting wins over the spend in the same cycle; a held credit absorbs extras
        next_s.credit = 1'b1;
        if (s.syn_sent) begin
          next_s.tx_est = 1'b1;
        end
      end else if (rx_data == bhl_pkg::CHAR_SYN) begin
        if (s.syn_sent) begin
          next_s.tx_est = 1'b1;
        end
        next_s.echo_pend = 1'b1;
      end else begin
        next_s.cmd_valid = 1'b1;
        next_s.cmd_data = rx_data;
      end
    end else if (rx_valid) begin
      next_s.cmd_valid = 1'b1;
      next_s.cmd_data = rx_data;
    end
    // Command side asks for one more command; only sent once receive side is set
    if (cmd_ack_req && s.rx_est) begin
      next_s.ack_pend = 1'b1;
    end
    // Indicator blink timebase
    if (s.blink_cnt >= CW'(BLINK_CYCLES - 1)) begin
      next_s.blink_cnt = '0;
      next_s.blink = !s.blink;
    end else begin
      next_s.blink_cnt = s.blink_cnt + CW'(1);
    end
    // Only these three events drop an established handshake
    if (line_break || !block_mode || (block_mode && !s.was_block)) begin
      next_s.settle_cnt = '0;
      next_s.settled = 1'b0;
      next_s.syn_sent = 1'b0;
      next_s.tx_est = 1'b0;
      next_s.rx_est = 1'b0;
      next_s.credit = 1'b0;
      next_s.echo_pend = 1'b0;
      next_s.ack_pend = 1'b0;
    end
  end
  // ------------------------------------------------------------
  // Control character requests
  // ------------------------------------------------------------
  // Echo and acknowledge are sent only after the peer proved it speaks the protocol
  assign ctrl.req = block_mode && !line_break &&
                    ((s.settled && !s.syn_sent) || s.echo_pend || s.ack_pend);
  // Same priority as the completion decode, so a finished character clears the right flag
  assign ctrl.code = (s.ack_pend && !s.echo_pend) ? bhl_pkg::CHAR_ACK : bhl_pkg::CHAR_SYN;
  // ------------------------------------------------------------
  // Message release
  // ------------------------------------------------------------
  // A whole line goes per credit; without setup, lines flow freely
  assign msg_start = msg_pending && !busy && !ctrl.req && !line_break &&
                     (!block_mode || !s.tx_est || s.credit) &&
                     (block_mode || hw_send_ok);
  bhl_tx_mux u_mux (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ctrl(ctrl.sender),
    .block_mode(block_mode),
    .lf_suppress(lf_suppress),
    .msg_start(msg_start),
    .msg_valid(msg_valid),
    .msg_data(msg_data),
    .msg_last(msg_last),
    .msg_ready(msg_ready),
    .busy(busy),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready)
  );
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign tx_est = s.tx_est;
  assign rx_est = s.rx_est;
  assign rx_cmd_valid = s.cmd_valid;
  assign rx_cmd_data = s.cmd_data;
  // Break blanks the lamp; both ways set holds it on; otherwise it blinks
  assign io_lamp = !line_break && ((s.tx_est && s.rx_est) || s.blink);
  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : bhl_link

// File: hdl/bhl_pkg.sv
// Package of constants and types for the block handshake link layer
package bhl_pkg;
  // ------------------------------------------------------------
  // Character codes
  // ------------------------------------------------------------
  localparam logic [7:0] CHAR_SYN = 8'h16; // Synchronous idle, ASCII 22
  localparam logic [7:0] CHAR_ACK = 8'h06; // Acknowledge, ASCII 06
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  // ------------------------------------------------------------
  // Handshake modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BHL_MODE_PAUSE = 2'b00,
    BHL_MODE_HARD = 2'b01,
    BHL_MODE_SOFT = 2'b10,
    BHL_MODE_BLOCK = 2'b11
  } bhl_mode_t;
  localparam logic [1:0] MODE_DEFAULT = 2'b00; // Fixed inter-line pause
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_MS = 200;
  localparam int SETTLE_CYCLES = SETTLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYCLES = BLINK_MS * 1000000 / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // Transmit arbiter states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    BHL_TX_IDLE = 3'b000,
    BHL_TX_CTRL = 3'b001,
    BHL_TX_BODY = 3'b010,
    BHL_TX_CR = 3'b011,
    BHL_TX_LF = 3'b100
  } bhl_tx_state_t;
endpackage : bhl_pkg

// File: hdl/bhl_tx_mux.sv
// Transmit character sequencer: control characters, message bodies and line ends
`timescale 1ns/1ps
module bhl_tx_mux (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  bhl_ctrl_if.sender ctrl, // Control character requests
  input wire logic block_mode, // Block handshake active
  input wire logic lf_suppress, // Configured to drop line feed
  input wire logic msg_start, // Pulse: begin sending the pending message
  input wire logic msg_valid, // Body character available
  input wire logic [7:0] msg_data, // Body character
  input wire logic msg_last, // Body character is the last of the line
  output logic msg_ready, // Body character taken
  output logic busy, // A message is in flight
  output logic tx_valid, // Character to serial transmitter
  output logic [7:0] tx_data, // Character value
  input wire logic tx_ready // Serial transmitter accepts
);
  typedef struct packed {
    bhl_pkg::bhl_tx_state_t st;
  } bhl_mux_state_t;
  bhl_mux_state_t s, next_s;
  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Control characters go between lines only, so a line is never split
  always_comb begin
    next_s = s;
    ctrl.done = 1'b0;
    msg_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    case (s.st)
      bhl_pkg::BHL_TX_IDLE: begin
        if (ctrl.req) begin
          next_s.st = bhl_pkg::BHL_TX_CTRL;
        end else if (msg_start) begin
          next_s.st = bhl_pkg::BHL_TX_BODY;
        end
      end
      bhl_pkg::BHL_TX_CTRL: begin
        tx_valid = 1'b1;
        tx_data = ctrl.code;
        if (tx_ready) begin
          ctrl.done = 1'b1;
          next_s.st = bhl_pkg::BHL_TX_IDLE;
        end
      end
      bhl_pkg::BHL_TX_BODY: begin
        tx_valid = msg_valid;
        tx_data = msg_data;
        if (msg_valid && tx_ready) begin
          msg_ready = 1'b1;
          if (msg_last) begin
            next_s.st = bhl_pkg::BHL_TX_CR;
          end
        end
      end
      bhl_pkg::BHL_TX_CR: begin
        tx_valid = 1'b1;
        tx_data = bhl_pkg::CHAR_CR;
        if (tx_ready) begin
          // Block mode needs the line feed as its terminator
          if (lf_suppress && !block_mode) begin
            next_s.st = bhl_pkg::BHL_TX_IDLE;
          end else begin
            next_s.st = bhl_pkg::BHL_TX_LF;
          end
        end
      end
      bhl_pkg::BHL_TX_LF: begin
        tx_valid = 1'b1;
        tx_data = bhl_pkg::CHAR_LF;
        if (tx_ready) begin
          next_s.st = bhl_pkg::BHL_TX_IDLE;
        end
      end
      default: begin
        next_s.st = bhl_pkg::BHL_TX_IDLE;
      end
    endcase
  end
  assign busy = (s.st == bhl_pkg::BHL_TX_BODY) || (s.st == bhl_pkg::BHL_TX_CR) ||
                (s.st == bhl_pkg::BHL_TX_LF);
  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: bhl_pkg::BHL_TX_IDLE};
    end else begin
      s <= next_s;
    end
  end
endmodule : bhl_tx_mux
